//--- rtl/soe_regs.svh
// Constants for the serial output-enable slave
`ifndef SOE_REGS_SVH
`define SOE_REGS_SVH

// ==========================================================================
// Slave address and byte positions
// ==========================================================================
`define SOE_ADDR_BYTE      8'hd2
`define SOE_IDX_W          3
`define SOE_IDX_ADDR       3'h0
`define SOE_IDX_CMD        3'h1
`define SOE_IDX_COUNT      3'h2
`define SOE_IDX_DATA0      3'h3
`define SOE_IDX_DATA1      3'h4
`define SOE_IDX_BEYOND     3'h5
`define SOE_IDX_ONE        3'h1
`define SOE_RW_MASK        8'h01

// ==========================================================================
// Byte framing
// ==========================================================================
`define SOE_BYTE_W         8
`define SOE_BYTE_MSB       7
`define SOE_BIT_CNT_W      4
`define SOE_BITS_PER_BYTE  4'h8
`define SOE_BIT_CNT_ZERO   4'h0
`define SOE_BIT_CNT_ONE    4'h1

// ==========================================================================
// Register reset values and field layout
// ==========================================================================
`define SOE_GROUP_A_RST    8'hff
`define SOE_GROUP_B_RST    8'hc0
`define SOE_GROUP_B_MASK   8'hc0
`define SOE_PAIRS          10
`define SOE_GROUP_A_PAIRS  8
`define SOE_COUNT_RST      8'h00

// ==========================================================================
// Timing
// ==========================================================================
`define SOE_SCL_MAX_KHZ    100
`define SOE_OVERSAMPLE_MIN 20
`define SOE_CORE_CLK_KHZ   250000

`endif

//--- rtl/soe_pkg.sv
// Types shared by the serial output-enable slave
package soe_pkg;
  `include "soe_regs.svh"

  typedef enum logic [1:0] {
    SOE_IDLE,
    SOE_RECV,
    SOE_ACK,
    SOE_IGNORE
  } soe_state_e;

  typedef logic [`SOE_BYTE_W-1:0]    soe_byte_t;
  typedef logic [`SOE_IDX_W-1:0]     soe_idx_t;
  typedef logic [`SOE_BIT_CNT_W-1:0] soe_bitcnt_t;

  typedef struct packed {
    soe_state_e  state;
    soe_idx_t    byte_idx;
    soe_bitcnt_t bit_cnt;
    soe_byte_t   shift;
    logic        scl_q;
    logic        sda_q;
    logic        ack_drive;
    logic        addressed;
    soe_byte_t   group_a;
    soe_byte_t   group_b;
    soe_byte_t   byte_count;
    logic        wr_pulse;
  } soe_state_s;
endpackage : soe_pkg

//--- rtl/soe_sync.sv
// Two-stage synchroniser for pin inputs
`timescale 1ns/1ns
module soe_sync #(
  parameter int unsigned         WIDTH     = 1,
  parameter logic [WIDTH-1:0]    RESET_VAL = '1
) (
  input  wire logic             i_core_clk,
  input  wire logic             i_reset_n,
  input  wire logic             i_clk_en,
  input  wire logic [WIDTH-1:0] i_async,
  output logic      [WIDTH-1:0] o_sync
);

  typedef struct packed {
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
  } soe_sync_s;

  soe_sync_s sync_reg;
  soe_sync_s sync_next;

  // ========================================================================
  // Parameter check
  // ========================================================================
  initial begin
    if (WIDTH < 1) begin
      $error("soe_sync: WIDTH must be at least one");
    end
  end

  // ========================================================================
  // Stages
  // ========================================================================
  always_comb begin
    sync_next        = sync_reg;
    sync_next.stage1 = i_async;
    sync_next.stage2 = sync_reg.stage1;
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      sync_reg.stage1 <= RESET_VAL;
      sync_reg.stage2 <= RESET_VAL;
    end else if (i_clk_en) begin
      sync_reg <= sync_next;
    end
  end

  assign o_sync = sync_reg.stage2;

endmodule // soe_sync

//--- rtl/soe_slave.sv
// Two-wire write-only slave driving ten output pair enables
// How it works
// - Only first byte D2 hex (address plus write bit) is recognised.
// - Bytes run address, command, count, data 0, data 1 in order.
// - Command byte value is thrown away and changes nothing.
// - After reset every pair enable is high, pairs running.
// - Enable bit one runs the pair, zero sets it high impedance.
// - Data byte 0 bit 7 drives pair 0, down to bit 0 pair 7.
// - Data byte 1 bits 7,6 drive pairs 8,9; rest reserved, low.
// - Repeated start restarts address recognition like a fresh start.
// - While power down is low the data line stays released.
// - Standard-mode signalling, host clock at most 100 kHz.
`timescale 1ns/1ns
`include "soe_regs.svh"
module soe_slave
  import soe_pkg::*;
#(
  parameter int unsigned CORE_CLK_KHZ = `SOE_CORE_CLK_KHZ
) (
  input  wire logic                  i_core_clk,
  input  wire logic                  i_reset_n,
  input  wire logic                  i_clk_en,
  // Serial link pins
  input  wire logic                  i_serial_clock,
  input  wire logic                  i_serial_data_line_i,
  output logic                       o_serial_data_line_o,
  output logic                       o_serial_data_line_oe,
  input  wire logic                  i_power_down_n,
  // Output pair control
  output logic [`SOE_PAIRS-1:0]      o_output_pair_en,
  output logic [`SOE_BYTE_W-1:0]     o_output_enable_group_a,
  output logic [`SOE_BYTE_W-1:0]     o_output_enable_group_b,
  // Status
  output logic [`SOE_BYTE_W-1:0]     o_byte_count,
  output logic                       o_write_strobe,
  output logic                       o_busy
);

  // ========================================================================
  // Derived constants
  // ========================================================================
  localparam int unsigned min_core_khz  =
    `SOE_OVERSAMPLE_MIN * `SOE_SCL_MAX_KHZ;
  localparam int unsigned group_b_pairs = `SOE_PAIRS - `SOE_GROUP_A_PAIRS;

  // ========================================================================
  // Parameter check
  // ========================================================================
  // The line edges are found by oversampling, so the core must run
  // well above the fastest serial clock.
  initial begin
    if (CORE_CLK_KHZ < min_core_khz) begin
      $error("soe_slave: core clock too slow for the serial clock");
    end
    // Group b holds only as many pair bits as its mask keeps
    if (group_b_pairs != $countones(`SOE_GROUP_B_MASK)) begin
      $error("soe_slave: pair count does not fit the two groups");
    end
    // A full byte must be where the bit counter stops
    if (`SOE_BITS_PER_BYTE != `SOE_BYTE_W) begin
      $error("soe_slave: bit count and byte width disagree");
    end
    // Only writes are served, so the address must carry a write bit
    if ((`SOE_ADDR_BYTE & `SOE_RW_MASK) != '0) begin
      $error("soe_slave: slave address must select a write");
    end
    // Positions past data 1 must follow it in the byte order
    if (`SOE_IDX_BEYOND <= `SOE_IDX_DATA1) begin
      $error("soe_slave: byte positions out of order");
    end
  end

  // ========================================================================
  // Declarations
  // ========================================================================
  soe_state_s state_reg;
  soe_state_s state_next;

  logic [1:0] pins_sync;
  logic       scl_s;
  logic       sda_s;
  logic       pd_n_s;

  logic       scl_rise;
  logic       scl_fall;
  logic       start_seen;
  logic       stop_seen;
  logic       byte_full;

  // ========================================================================
  // Pin synchronisers
  // ========================================================================
  soe_sync #(
    .WIDTH     (2),
    .RESET_VAL (2'h3)
  ) u_line_sync (
    .i_core_clk (i_core_clk),
    .i_reset_n  (i_reset_n),
    .i_clk_en   (i_clk_en),
    .i_async    ({i_serial_clock, i_serial_data_line_i}),
    .o_sync     (pins_sync)
  );

  // Power down starts out asserted so a held-low pin is seen at once
  soe_sync #(
    .WIDTH     (1),
    .RESET_VAL (1'h0)
  ) u_pd_sync (
    .i_core_clk (i_core_clk),
    .i_reset_n  (i_reset_n),
    .i_clk_en   (i_clk_en),
    .i_async    (i_power_down_n),
    .o_sync     (pd_n_s)
  );

  assign scl_s = pins_sync[1];
  assign sda_s = pins_sync[0];

  // ========================================================================
  // Line event detection
  // ========================================================================
  // Data moving while the clock is high marks start or stop; a start
  // in mid-transfer is a repeated start and is treated the same.
  assign scl_rise   = scl_s & ~state_reg.scl_q;
  assign scl_fall   = ~scl_s & state_reg.scl_q;
  assign start_seen = state_reg.sda_q & ~sda_s & scl_s & state_reg.scl_q;
  assign stop_seen  = ~state_reg.sda_q & sda_s & scl_s & state_reg.scl_q;
  assign byte_full  = (state_reg.bit_cnt == `SOE_BITS_PER_BYTE);

  // ========================================================================
  // Next-state logic
  // ========================================================================
  always_comb begin
    state_next          = state_reg;
    state_next.scl_q    = scl_s;
    state_next.sda_q    = sda_s;
    state_next.wr_pulse = 1'b0;

    if (!pd_n_s) begin
      // Powered down: bus ignored, data line released
      state_next.state     = SOE_IDLE;
      state_next.ack_drive = 1'b0;
      state_next.addressed = 1'b0;
      state_next.byte_idx  = `SOE_IDX_ADDR;
      state_next.bit_cnt   = `SOE_BIT_CNT_ZERO;
    end else if (start_seen) begin
      // Fresh or repeated start, address expected next
      state_next.state     = SOE_RECV;
      state_next.shift     = `SOE_COUNT_RST;
      state_next.byte_idx  = `SOE_IDX_ADDR;
      state_next.bit_cnt   = `SOE_BIT_CNT_ZERO;
      state_next.ack_drive = 1'b0;
      state_next.addressed = 1'b0;
    end else if (stop_seen) begin
      state_next.state     = SOE_IDLE;
      state_next.ack_drive = 1'b0;
      state_next.addressed = 1'b0;
      state_next.byte_idx  = `SOE_IDX_ADDR;
      state_next.bit_cnt   = `SOE_BIT_CNT_ZERO;
    end else begin
      case (state_reg.state)
        SOE_IDLE: begin
          state_next.ack_drive = 1'b0;
          state_next.addressed = 1'b0;
        end

        SOE_RECV: begin
          if (scl_rise && !byte_full) begin
            // Sample the bit, most significant first
            state_next.shift   = {state_reg.shift[`SOE_BYTE_MSB-1:0],
                                  sda_s};
            state_next.bit_cnt = state_reg.bit_cnt + `SOE_BIT_CNT_ONE;
          end else if (scl_fall && byte_full) begin
            // Eighth bit complete, decide on the ninth clock
            state_next.state     = SOE_ACK;
            state_next.ack_drive = 1'b1;
            case (state_reg.byte_idx)
              `SOE_IDX_ADDR: begin
                if (state_reg.shift == `SOE_ADDR_BYTE) begin
                  state_next.addressed = 1'b1;
                end else begin
                  // Other address or read: stay silent
                  state_next.state     = SOE_IGNORE;
                  state_next.ack_drive = 1'b0;
                end
              end
              `SOE_IDX_CMD: begin
                // Command value dropped
                state_next.addressed = state_reg.addressed;
              end
              `SOE_IDX_COUNT: begin
                state_next.byte_count = state_reg.shift;
              end
              `SOE_IDX_DATA0: begin
                state_next.group_a  = state_reg.shift;
                state_next.wr_pulse = 1'b1;
              end
              `SOE_IDX_DATA1: begin
                // Reserved bits forced low
                state_next.group_b  = state_reg.shift
                                      & `SOE_GROUP_B_MASK;
                state_next.wr_pulse = 1'b1;
              end
              default: begin
                // Bytes past data 1 acknowledged, not stored
                state_next.addressed = state_reg.addressed;
              end
            endcase
          end
        end

        SOE_ACK: begin
          // Release at the end of the ninth clock
          if (scl_fall) begin
            state_next.state     = SOE_RECV;
            state_next.ack_drive = 1'b0;
            state_next.bit_cnt   = `SOE_BIT_CNT_ZERO;
            if (state_reg.byte_idx != `SOE_IDX_BEYOND) begin
              // Strictly sequential register order
              state_next.byte_idx = state_reg.byte_idx + `SOE_IDX_ONE;
            end
          end
        end

        SOE_IGNORE: begin
          // Waits for the next start or stop
          state_next.ack_drive = 1'b0;
        end

        default: begin
          state_next.state     = SOE_IDLE;
          state_next.ack_drive = 1'b0;
        end
      endcase
    end
  end

  // ========================================================================
  // State register
  // ========================================================================
  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      state_reg.state      <= SOE_IDLE;
      state_reg.byte_idx   <= `SOE_IDX_ADDR;
      state_reg.bit_cnt    <= `SOE_BIT_CNT_ZERO;
      state_reg.shift      <= `SOE_COUNT_RST;
      state_reg.scl_q      <= 1'b1;
      state_reg.sda_q      <= 1'b1;
      state_reg.ack_drive  <= 1'b0;
      state_reg.addressed  <= 1'b0;
      state_reg.group_a    <= `SOE_GROUP_A_RST;
      state_reg.group_b    <= `SOE_GROUP_B_RST;
      state_reg.byte_count <= `SOE_COUNT_RST;
      state_reg.wr_pulse   <= 1'b0;
    end else if (i_clk_en) begin
      state_reg <= state_next;
    end
  end

  // ========================================================================
  // Serial data line
  // ========================================================================
  // Open drain: only ever pulls low, enable gated by power down
  assign o_serial_data_line_o  = 1'b0;
  assign o_serial_data_line_oe = state_reg.ack_drive & pd_n_s;

  // ========================================================================
  // Output pair enables
  // ========================================================================
  genvar g;
  generate
    for (g = 0; g < `SOE_PAIRS; g = g + 1) begin : g_pair
      if (g < `SOE_GROUP_A_PAIRS) begin : g_grp_a
        // Bit 7 to pair 0 downward
        assign o_output_pair_en[g] = state_reg.group_a[`SOE_BYTE_MSB-g];
      end else begin : g_grp_b
        // Bit 7 to pair 8, bit 6 to pair 9
        assign o_output_pair_en[g] =
          state_reg.group_b[`SOE_BYTE_MSB-(g-`SOE_GROUP_A_PAIRS)];
      end
    end
  endgenerate

  // ========================================================================
  // Register outputs
  // ========================================================================
  assign o_output_enable_group_a = state_reg.group_a;
  assign o_output_enable_group_b = state_reg.group_b;
  assign o_byte_count            = state_reg.byte_count;

  // ========================================================================
  // Status outputs
  // ========================================================================
  // Strobe marks one stored data byte for a single cycle
  assign o_write_strobe          = state_reg.wr_pulse;
  // Busy from address acknowledge until stop, start or power down
  assign o_busy                  = state_reg.addressed;

endmodule // soe_slave

//--- dv/soe_slave_chk.sv
// Port assertions for the serial output-enable slave
`timescale 1ns/1ns
module soe_slave_chk (
  input wire logic       i_core_clk,
  input wire logic       i_reset_n,
  input wire logic       i_power_down_n,
  input wire logic       o_serial_data_line_o,
  input wire logic       o_serial_data_line_oe,
  input wire logic [9:0] o_output_pair_en,
  input wire logic [7:0] o_output_enable_group_a,
  input wire logic [7:0] o_output_enable_group_b,
  input wire logic       o_write_strobe,
  input wire logic       o_busy
);
  // ========
  // Properties
  logic [7:0] ga;
  logic [7:0] gb;
  assign ga = o_output_enable_group_a;
  assign gb = o_output_enable_group_b;

  property p_reset;
    @(posedge i_core_clk) !i_reset_n |=> o_output_pair_en == 10'h3ff &&
      ga == 8'hff && gb == 8'hc0 && !o_busy && !o_serial_data_line_oe;
  endproperty
  a_reset: assert property (p_reset) else $error("bad reset state");

  property p_map;
    @(posedge i_core_clk) disable iff (!i_reset_n) o_output_pair_en ==
      {gb[6], gb[7], ga[0], ga[1], ga[2], ga[3], ga[4], ga[5], ga[6], ga[7]};
  endproperty
  a_map: assert property (p_map) else $error("pair map wrong");

  property p_reserved;
    @(posedge i_core_clk) disable iff (!i_reset_n) gb[5:0] == 6'h00;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved set");

  property p_pd_oe;
    @(posedge i_core_clk) disable iff (!i_reset_n)
      !i_power_down_n [*3] |-> !o_serial_data_line_oe;
  endproperty
  a_pd_oe: assert property (p_pd_oe) else $error("ack in power down");

  property p_pd_busy;
    @(posedge i_core_clk) disable iff (!i_reset_n)
      !i_power_down_n [*4] |-> !o_busy;
  endproperty
  a_pd_busy: assert property (p_pd_busy) else $error("busy while off");

  property p_oe_hold;
    @(posedge i_core_clk) disable iff (!i_reset_n) $rose(o_serial_data_line_oe)
      |-> o_serial_data_line_oe [*8] ##0 !o_serial_data_line_o;
  endproperty
  a_oe_hold: assert property (p_oe_hold) else $error("ack too short");

  property p_change;
    @(posedge i_core_clk) disable iff (!i_reset_n)
      $changed(ga) || $changed(gb) |-> ##[0:1] o_write_strobe;
  endproperty
  a_change: assert property (p_change) else $error("silent change");

  property p_strobe;
    @(posedge i_core_clk) disable iff (!i_reset_n)
      o_write_strobe |=> !o_write_strobe;
  endproperty
  a_strobe: assert property (p_strobe) else $error("strobe too long");
endmodule // soe_slave_chk

bind soe_slave soe_slave_chk u_chk (
  .i_core_clk             (i_core_clk),
  .i_reset_n              (i_reset_n),
  .i_power_down_n         (i_power_down_n),
  .o_serial_data_line_o   (o_serial_data_line_o),
  .o_serial_data_line_oe  (o_serial_data_line_oe),
  .o_output_pair_en       (o_output_pair_en),
  .o_output_enable_group_a(o_output_enable_group_a),
  .o_output_enable_group_b(o_output_enable_group_b),
  .o_write_strobe         (o_write_strobe),
  .o_busy                 (o_busy)
);

//--- dv/soe_host.sv
// Bus host model driving serial clock and data line
`timescale 1ns/1ns
module soe_host (
  input  wire logic i_core_clk,
  input  wire logic i_sda,
  output logic      o_scl,
  output logic      o_sda_low
);
  // ========
  // Quarter of a 160 ns serial period; clock idles high
  initial begin
    o_scl = 1'b1;
    o_sda_low = 1'b0;
  end
  task automatic q();
    repeat (10) @(posedge i_core_clk);
    #1;
  endtask
  task automatic start();
    o_sda_low = 1'b0;
    q();
    o_scl = 1'b1;
    q();
    o_sda_low = 1'b1;
    q();
    o_scl = 1'b0;
    q();
  endtask
  task automatic stop();
    o_sda_low = 1'b1;
    q();
    o_scl = 1'b1;
    q();
    o_sda_low = 1'b0;
    q();
  endtask
  // Eight bits MSB first, ninth clock samples the acknowledge
  task automatic send(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= -1; i--) begin
      o_sda_low = (i >= 0) ? !b[i] : 1'b0;
      q();
      o_scl = 1'b1;
      q();
      ack = !i_sda;
      q();
      o_scl = 1'b0;
      q();
    end
  endtask
endmodule // soe_host

//--- dv/tb.sv
// Self-checking bench for the serial output-enable slave
`timescale 1ns/1ns
module tb
  import soe_pkg::*;
;
  logic       i_core_clk, i_reset_n, i_power_down_n;
  logic       scl, host_low, sda, sda_o, sda_oe, strobe, busy, ack;
  logic [9:0] pair_en;
  soe_byte_t  grp_a, grp_b, cnt, ea, eb, ec;
  int         errors = 0;
  int         n_compared = 0;
  int         cycles = 0;
  int         n_strobe = 0;
  int         exp_strobe = 0;
  int         nbt [6] = '{5, 4, 6, 6, 3, 5};
  soe_byte_t  tv [6][6] = '{
    '{8'hd2, 8'ha5, 8'h02, 8'h5a, 8'h3f, 8'h00},
    '{8'hd2, 8'hff, 8'h02, 8'h81, 8'hc0, 8'h00},
    '{8'hd2, 8'h00, 8'h03, 8'hff, 8'h40, 8'hff},
    '{8'hd4, 8'hd2, 8'h02, 8'h00, 8'h00, 8'h00},
    '{8'hd3, 8'h00, 8'h02, 8'h00, 8'h00, 8'h00},
    '{8'hd2, 8'h12, 8'h01, 8'h00, 8'h80, 8'h00}};

  // Open-drain wire with pull-up
  assign sda = !host_low && !(sda_oe && !sda_o);
  initial begin
    i_core_clk = 1'b0;
    forever #2 i_core_clk = ~i_core_clk;
  end

  soe_slave dut (
    .i_core_clk             (i_core_clk),
    .i_reset_n              (i_reset_n),
    .i_clk_en               (1'b1),
    .i_serial_clock         (scl),
    .i_serial_data_line_i   (sda),
    .o_serial_data_line_o   (sda_o),
    .o_serial_data_line_oe  (sda_oe),
    .i_power_down_n         (i_power_down_n),
    .o_output_pair_en       (pair_en),
    .o_output_enable_group_a(grp_a),
    .o_output_enable_group_b(grp_b),
    .o_byte_count           (cnt),
    .o_write_strobe         (strobe),
    .o_busy                 (busy));
  soe_host host (
    .i_core_clk(i_core_clk),
    .i_sda     (sda),
    .o_scl     (scl),
    .o_sda_low (host_low));

  // ========
  // Checking
  task automatic conclude();
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  always @(posedge i_core_clk) begin
    cycles <= cycles + 1;
    if (strobe === 1'b1) begin
      n_strobe <= n_strobe + 1;
    end
    if (cycles == 30000) begin
      errors++;
      conclude();
    end
  end
  task automatic chk(input string nm, input logic [9:0] exp, got);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask
  function automatic logic [9:0] pairs(input soe_byte_t a, b);
    logic [9:0] r;
    for (int k = 0; k < 8; k++) begin
      r[k] = a[7-k];
    end
    r[8] = b[7];
    r[9] = b[6];
    return r;
  endfunction
  task automatic regs();
    chk("pairs", pairs(ea, eb), pair_en);
    chk("group a", 10'(ea), 10'(grp_a));
    chk("group b", 10'(eb), 10'(grp_b));
    chk("count", 10'(ec), 10'(cnt));
    chk("busy", 10'h000, 10'(busy));
    chk("strobes", 10'(exp_strobe), 10'(n_strobe));
  endtask
  // One write transaction; acks expected only for our address
  task automatic wr(input soe_byte_t t[6], input int nb);
    logic ok;
    ok = t[0] === 8'hd2 && i_power_down_n === 1'b1;
    host.start();
    for (int i = 0; i < nb; i++) begin
      host.send(t[i], ack);
      chk("ack", 10'(ok), 10'(ack));
      if (i == 0) begin
        chk("busy", 10'(ok), 10'(busy));
      end
    end
    ec = (ok && nb > 2) ? t[2] : ec;
    ea = (ok && nb > 3) ? t[3] : ea;
    eb = (ok && nb > 4) ? (t[4] & 8'hc0) : eb;
    exp_strobe += (ok && nb > 3) ? 1 : 0;
    exp_strobe += (ok && nb > 4) ? 1 : 0;
    host.stop();
    repeat (8) @(posedge i_core_clk);
    regs();
  endtask

  // ========
  // Main sequence
  initial begin
    i_reset_n = 1'b0;
    i_power_down_n = 1'b1;
    ea = 8'hff;
    eb = 8'hc0;
    ec = 8'h00;
    repeat (8) @(posedge i_core_clk);
    #1;
    i_reset_n = 1'b1;
    repeat (4) @(posedge i_core_clk);
    regs();
    for (int j = 0; j < 6; j++) begin
      wr(tv[j], nbt[j]);
    end
    host.start();
    host.send(8'hd4, ack);
    chk("nack", 10'h000, 10'(ack));
    wr(tv[0], 5);
    #1;
    i_power_down_n = 1'b0;
    repeat (4) @(posedge i_core_clk);
    wr(tv[2], 5);
    conclude();
  end
endmodule // tb
